// File: sbcg_acc.sv
// Purpose: one block check accumulator, parity sum or crc
// Assumes: one character per enabled cycle, bit 7 first into crc
// Notes:   clear and enable together start a fresh block with that char
`timescale 1ns/1ps
`include "sbcg_defs.svh"

module sbcg_acc
  import sbcg_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    clr,
  input  wire logic                    en,
  input  wire logic [`SBCG_CHAR_W-1:0] data,
  input  wire sbcg_mode_e              mode,
  output logic      [`SBCG_BCC_W-1:0]  acc_q
);

  logic [`SBCG_BCC_W-1:0] base;
  logic [`SBCG_BCC_W-1:0] acc_d;

  // bitwise long division, borrows dropped, quotient discarded
  function automatic logic [`SBCG_BCC_W-1:0] crc_step(
    input logic [`SBCG_BCC_W-1:0]  rem,
    input logic [`SBCG_CHAR_W-1:0] ch,
    input logic [`SBCG_BCC_W-1:0]  poly
  );
    logic [`SBCG_BCC_W-1:0] r;
    logic                   fb;
    r = rem;
    for (int i = `SBCG_CHAR_W - 1; i >= 0; i--) begin
      fb = r[`SBCG_BCC_W-1] ^ ch[i];
      r  = {r[`SBCG_BCC_W-2:0], 1'b0} ^ (fb ? poly : `SBCG_ACC_RST);
    end
    return r;
  endfunction

  // clear before the first counted character
  assign base = clr ? `SBCG_ACC_RST : acc_q;

  // per-mode update of the running check
  always_comb begin
    acc_d = base;
    if (en) begin
      unique case (mode)
        BCC_CRC16: acc_d = crc_step(base, data, `SBCG_POLY_CRC16);
        BCC_CCITT: acc_d = crc_step(base, data, `SBCG_POLY_CCITT);
        default:   acc_d = {8'h00, base[7:0] ^ data};
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_q <= `SBCG_ACC_RST;
    end else begin
      acc_q <= acc_d;
    end
  end

endmodule

// File: sbcg_core.sv
// Purpose: sync block check generator, transmit and receive character path
// Assumes: rx line pins are asynchronous; everything else is on clk
// Notes:   a block with its check appended divides to a zero remainder,
//          so receive checks by folding the sent check into the sum
`timescale 1ns/1ps
`include "sbcg_defs.svh"

module sbcg_core
  import sbcg_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire sbcg_mode_e                 bcc_mode,
  input  wire logic                       par_en,
  input  wire logic [`SBCG_CHAR_W-1:0]    sync_char,
  input  wire logic [`SBCG_SYNC_CNT_W-1:0] sync_count,
  input  wire logic                       tx_blk_start,
  input  wire logic                       tx_in_valid,
  output logic                            tx_in_ready,
  input  wire logic [`SBCG_CHAR_W-1:0]    tx_in_data,
  input  wire logic                       tx_in_last,
  output logic                            tx_busy,
  output logic                            tx_out_valid,
  input  wire logic                       tx_out_ready,
  output logic      [`SBCG_CHAR_W-1:0]    tx_out_data,
  input  wire logic                       rx_line_data,
  input  wire logic                       rx_line_clk,
  input  wire logic                       rx_hunt,
  output logic                            rx_framed,
  output logic                            rx_char_valid,
  output logic      [`SBCG_CHAR_W-1:0]    rx_char_data,
  output logic                            rx_par_err,
  input  wire logic                       rx_count_en,
  input  wire logic                       rx_blk_start,
  input  wire logic                       rx_blk_end,
  output logic                            rx_good,
  output logic                            rx_bad
);

  // ----------------------------------------------------------------------
  // transmit sequencer
  // ----------------------------------------------------------------------
  sbcg_tx_e                     tx_st_q;
  sbcg_tx_e                     tx_st_d;
  logic [`SBCG_SYNC_CNT_W-1:0]  sync_left_q;
  logic [`SBCG_SYNC_CNT_W-1:0]  sync_left_d;
  logic [`SBCG_SYNC_CNT_W-1:0]  sync_load;
  logic [`SBCG_CHAR_W-1:0]      tx_char;
  logic [`SBCG_CHAR_W-1:0]      push_data;
  logic [`SBCG_BCC_W-1:0]       tx_acc;
  logic                         push_valid;
  logic                         push;
  logic                         buf_in_ready;
  logic                         tx_is_crc;
  logic                         tx_acc_clr;
  logic                         tx_acc_en;
  logic                         tx_start_ok;

  // zero requested syncs still sends one
  assign sync_load = (sync_count == '0) ? `SBCG_SYNC_CNT_W'(1) : sync_count;
  // odd parity replaces bit 7 when seven-bit code is in use
  assign tx_char = par_en ?
                   {~^tx_in_data[6:0], tx_in_data[6:0]} : tx_in_data;
  assign tx_is_crc   = (bcc_mode == BCC_CRC16) || (bcc_mode == BCC_CCITT);
  assign tx_start_ok = (tx_st_q == TX_IDLE) && tx_blk_start;
  assign tx_busy     = (tx_st_q != TX_IDLE);

  // what goes into the output buffer in each phase
  assign push_valid = (tx_st_q == TX_SYNC) || (tx_st_q == TX_BCC_HI) ||
                      (tx_st_q == TX_BCC_LO) ||
                      ((tx_st_q == TX_DATA) && tx_in_valid);
  assign push        = push_valid && buf_in_ready;
  assign tx_in_ready = (tx_st_q == TX_DATA) && buf_in_ready;
  assign tx_acc_clr  = tx_start_ok;
  assign tx_acc_en   = (tx_st_q == TX_DATA) && tx_in_valid && buf_in_ready;

  // crc check goes out high byte first so the far end divides in order; the parity sum goes out as its one low byte
  always_comb begin
    push_data = `SBCG_CHAR_RST;
    unique case (tx_st_q)
      TX_SYNC:   push_data = sync_char;
      TX_DATA:   push_data = tx_char;
      TX_BCC_HI: push_data = tx_is_crc ? tx_acc[15:8] : tx_acc[7:0];
      TX_BCC_LO: push_data = tx_acc[7:0];
      TX_IDLE:   push_data = `SBCG_CHAR_RST;
    endcase
  end

  // phase steps past idle advance only on an accepted push; idle leaves on the start strobe alone
  always_comb begin
    tx_st_d     = tx_st_q;
    sync_left_d = sync_left_q;
    unique case (tx_st_q)
      TX_IDLE: begin
        if (tx_blk_start) begin
          tx_st_d     = TX_SYNC;
          sync_left_d = sync_load;
        end
      end
      TX_SYNC: begin
        if (push) begin
          sync_left_d = sync_left_q - `SBCG_SYNC_CNT_W'(1);
          if (sync_left_q == `SBCG_SYNC_CNT_W'(1)) begin
            tx_st_d = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (push && tx_in_last) begin
          tx_st_d = TX_BCC_HI;
        end
      end
      TX_BCC_HI: begin
        if (push) begin
          tx_st_d = tx_is_crc ? TX_BCC_LO : TX_IDLE;
        end
      end
      TX_BCC_LO: begin
        if (push) begin
          tx_st_d = TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st_q     <= TX_IDLE;
      sync_left_q <= '0;
    end else begin
      tx_st_q     <= tx_st_d;
      sync_left_q <= sync_left_d;
    end
  end

  // transmit check, sync characters kept out of it
  sbcg_acc u_tx_acc (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clr     (tx_acc_clr),
    .en      (tx_acc_en),
    .data    (tx_char),
    .mode    (bcc_mode),
    .acc_q   (tx_acc)
  );

  // ----------------------------------------------------------------------
  // two-entry output buffer
  // ----------------------------------------------------------------------
  logic [`SBCG_CHAR_W-1:0]   ent0_q;
  logic [`SBCG_CHAR_W-1:0]   ent1_q;
  logic [`SBCG_BUF_CNT_W-1:0] fill_q;
  logic                      pop;

  // full refuses a push even while popping; simpler, costs one cycle
  assign buf_in_ready = (fill_q != `SBCG_BUF_CNT_W'(2));
  assign tx_out_valid = (fill_q != '0);
  assign tx_out_data  = ent0_q;
  assign pop          = tx_out_valid && tx_out_ready;

  // head in ent0, second word in ent1
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ent0_q <= `SBCG_CHAR_RST;
      ent1_q <= `SBCG_CHAR_RST;
      fill_q <= '0;
    end else begin
      if (pop) begin
        ent0_q <= ent1_q;
      end
      if (push && (fill_q == '0 || (pop && fill_q == 2'h1))) begin
        ent0_q <= push_data;
      end
      if (push && ((fill_q == 2'h1 && !pop) || fill_q == 2'h2)) begin
        ent1_q <= push_data;
      end
      fill_q <= fill_q + `SBCG_BUF_CNT_W'(push) - `SBCG_BUF_CNT_W'(pop);
    end
  end

  // ----------------------------------------------------------------------
  // receive line synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] dat_s_q;
  logic [2:0] lclk_s_q;
  logic       dat_st_q;
  logic       lclk_st_q;
  logic       dat_st_d;
  logic       lclk_agree;
  logic       bit_take;

  // a level counts only once second and third stages agree
  assign dat_st_d   = (dat_s_q[1] == dat_s_q[2]) ? dat_s_q[2] : dat_st_q;
  assign lclk_agree = (lclk_s_q[1] == lclk_s_q[2]);
  assign bit_take   = lclk_agree && lclk_s_q[2] && !lclk_st_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dat_s_q   <= '0;
      lclk_s_q  <= '0;
      dat_st_q  <= 1'b0;
      lclk_st_q <= 1'b0;
    end else begin
      dat_s_q   <= {dat_s_q[1:0], rx_line_data};
      lclk_s_q  <= {lclk_s_q[1:0], rx_line_clk};
      dat_st_q  <= dat_st_d;
      lclk_st_q <= lclk_agree ? lclk_s_q[2] : lclk_st_q;
    end
  end

  // ----------------------------------------------------------------------
  // receive framing
  // ----------------------------------------------------------------------
  sbcg_rx_e                   rx_st_q;
  sbcg_rx_e                   rx_st_d;
  logic [`SBCG_CHAR_W-1:0]    shift_q;
  logic [`SBCG_CHAR_W-1:0]    shift_d;
  logic [`SBCG_BIT_CNT_W-1:0] bitcnt_q;
  logic [`SBCG_BIT_CNT_W-1:0] bitcnt_d;
  logic                       sync_hit;
  logic                       deliver;

  // newest bit enters at bit 0, first bit ends in bit 7
  assign shift_d  = rx_hunt  ? `SBCG_CHAR_RST : // stale bits fake no sync
                    bit_take ? {shift_q[6:0], dat_st_d} : shift_q;
  assign sync_hit = bit_take && (rx_st_q == RX_HUNT) &&
                    (shift_d == sync_char);
  assign deliver  = bit_take && (rx_st_q == RX_FRAMED) && !rx_hunt &&
                    (bitcnt_q == `SBCG_BIT_LAST);
  assign rx_framed = (rx_st_q == RX_FRAMED);

  // hunt request wins over any framing in progress
  always_comb begin
    rx_st_d  = rx_st_q;
    bitcnt_d = bitcnt_q;
    if (rx_hunt) begin
      rx_st_d  = RX_HUNT;
      bitcnt_d = '0;
    end else if (sync_hit) begin
      rx_st_d  = RX_FRAMED;
      bitcnt_d = '0;
    end else if (bit_take && rx_st_q == RX_FRAMED) begin
      bitcnt_d = bitcnt_q + `SBCG_BIT_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_st_q  <= RX_HUNT;
      bitcnt_q <= '0;
      shift_q  <= `SBCG_CHAR_RST;
    end else begin
      rx_st_q  <= rx_st_d;
      bitcnt_q <= bitcnt_d;
      shift_q  <= shift_d;
    end
  end

  // delivered character, one-cycle valid
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_char_valid <= 1'b0;
      rx_char_data  <= `SBCG_CHAR_RST;
      rx_par_err    <= 1'b0;
    end else begin
      rx_char_valid <= deliver;
      if (deliver) begin
        rx_char_data <= shift_d;
        rx_par_err   <= par_en && !(^shift_d);
      end
    end
  end

  // ----------------------------------------------------------------------
  // receive check
  // ----------------------------------------------------------------------
  logic [`SBCG_BCC_W-1:0] rx_acc;
  logic                   rx_acc_en;
  logic                   rx_zero;

  // caller chooses per character whether it counts, check bytes included
  assign rx_acc_en = rx_char_valid && rx_count_en;
  assign rx_zero   = (bcc_mode == BCC_CRC16 || bcc_mode == BCC_CCITT) ?
                     (rx_acc == `SBCG_ACC_RST) :
                     (rx_acc[7:0] == `SBCG_CHAR_RST);

  sbcg_acc u_rx_acc (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clr     (rx_blk_start),
    .en      (rx_acc_en),
    .data    (rx_char_data),
    .mode    (bcc_mode),
    .acc_q   (rx_acc)
  );

  // verdict pulses one cycle after the end strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_good <= 1'b0;
      rx_bad  <= 1'b0;
    end else begin
      rx_good <= rx_blk_end && rx_zero;
      rx_bad  <= rx_blk_end && !rx_zero;
    end
  end

endmodule

// File: sbcg_core_sva.sv
// Purpose: port checks for the sync block check generator
// Assumes: bound to sbcg_core, one clock, async high reset
// Notes:   watches design outputs against their causes
`timescale 1ns/1ps
`include "sbcg_defs.svh"

module sbcg_core_chk (
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire logic                    par_en,
  input wire logic [`SBCG_CHAR_W-1:0] sync_char,
  input wire logic                    tx_blk_start,
  input wire logic                    tx_busy,
  input wire logic                    tx_in_ready,
  input wire logic                    tx_out_valid,
  input wire logic                    tx_out_ready,
  input wire logic [`SBCG_CHAR_W-1:0] tx_out_data,
  input wire logic                    rx_hunt,
  input wire logic                    rx_framed,
  input wire logic                    rx_char_valid,
  input wire logic [`SBCG_CHAR_W-1:0] rx_char_data,
  input wire logic                    rx_par_err,
  input wire logic                    rx_blk_end,
  input wire logic                    rx_good,
  input wire logic                    rx_bad
);
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // a start only counts on an idle path with an empty buffer
  sequence s_start;
    tx_blk_start && !tx_busy && !tx_out_valid;
  endsequence
  sequence s_sync_out;
    tx_busy ##1 (tx_out_valid && tx_out_data == sync_char);
  endsequence

  chk_start_sync: assert property (s_start |=> s_sync_out)
    else $error("first sync not sent after start");
  chk_ready_busy: assert property (tx_in_ready |-> tx_busy)
    else $error("data taken outside a block");
  chk_stall_hold: assert property (tx_out_valid && !tx_out_ready
    |=> tx_out_valid && $stable(tx_out_data))
    else $error("output word lost during stall");
  chk_verdict_due: assert property (rx_blk_end |=> rx_good != rx_bad)
    else $error("no single verdict after block end");
  chk_verdict_why: assert property ((rx_good || rx_bad)
    |-> $past(rx_blk_end))
    else $error("verdict without block end");
  chk_char_pulse: assert property (rx_char_valid |=> !rx_char_valid)
    else $error("char valid longer than one cycle");
  chk_char_framed: assert property (rx_char_valid |-> rx_framed)
    else $error("char delivered while hunting");
  chk_hunt_wins: assert property (rx_hunt |=> !rx_framed)
    else $error("hunt did not drop framing");
  chk_par_odd: assert property (rx_char_valid && par_en
    |-> rx_par_err == ~^rx_char_data)
    else $error("odd parity flag wrong");
endmodule

bind sbcg_core sbcg_core_chk u_chk (.clk(clk), .sys_rst(sys_rst),
  .par_en(par_en), .sync_char(sync_char), .tx_blk_start(tx_blk_start),
  .tx_busy(tx_busy), .tx_in_ready(tx_in_ready),
  .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
  .tx_out_data(tx_out_data), .rx_hunt(rx_hunt), .rx_framed(rx_framed),
  .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
  .rx_par_err(rx_par_err), .rx_blk_end(rx_blk_end),
  .rx_good(rx_good), .rx_bad(rx_bad));

// File: sbcg_defs.svh
// Purpose: constants for the sync block check generator
// Assumes: included by its bare name by every design file but the package
// Notes:   definitions only
`ifndef SBCG_DEFS_SVH
`define SBCG_DEFS_SVH

// ----------------------------------------------------------------------
// character and check widths
// ----------------------------------------------------------------------
`define SBCG_CHAR_W     8
`define SBCG_BCC_W      16
`define SBCG_ACC_RST    16'h0000
`define SBCG_CHAR_RST   8'h00

// ----------------------------------------------------------------------
// generator polynomials, x^16 term implied
// ----------------------------------------------------------------------
`define SBCG_POLY_CRC16 16'h8005
`define SBCG_POLY_CCITT 16'h1021

// ----------------------------------------------------------------------
// character path
// ----------------------------------------------------------------------
`define SBCG_PAR_BIT    7
`define SBCG_SYNC_CNT_W 4
`define SBCG_BIT_CNT_W  3
`define SBCG_BIT_LAST   3'h7
`define SBCG_BUF_CNT_W  2

`endif

// File: sbcg_far_model.sv
// Purpose: serial path model: tx character sink and rx line sender
// Assumes: driven on the falling clock edge
// Notes:   line clock stands low between frames
`timescale 1ns/1ps
`include "sbcg_defs.svh"

module sbcg_far_model (
  input  wire logic                    clk,
  input  wire logic                    stall_all,
  input  wire logic                    tx_out_valid,
  input  wire logic [`SBCG_CHAR_W-1:0] tx_out_data,
  output logic                         tx_out_ready,
  output logic                         rx_line_clk,
  output logic                         rx_line_data
);
  // ----------------------------------------------------------------------
  // sink and sender
  // ----------------------------------------------------------------------
  logic [7:0] got[$];
  logic [4:0] stall_q = 5'h15;

  initial begin
    rx_line_clk = 1'b0;
    rx_line_data = 1'b1;
  end
  // irregular stalls so the two-entry buffer fills now and then
  always @(negedge clk) begin
    stall_q <= {stall_q[3:0], stall_q[4] ^ stall_q[2]};
    tx_out_ready <= !stall_all && stall_q[0];
  end
  // a word passes only where valid and ready meet at an edge
  always @(posedge clk) begin
    if (tx_out_valid && tx_out_ready) got.push_back(tx_out_data);
  end
  // msb first, bit taken on the rising line clock
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      rx_line_data = b[i];
      repeat (4) @(negedge clk);
      rx_line_clk = 1'b1;
      repeat (4) @(negedge clk);
      rx_line_clk = 1'b0;
    end
  endtask
  // released line shows no stale level
  task automatic idle();
    rx_line_data = !rx_line_data;
  endtask
endmodule

// File: sbcg_pkg.sv
// Purpose: types shared by the sync block check generator
// Assumes: nothing
// Notes:   mode code 3 is unused and falls back to the parity sum
package sbcg_pkg;

  // check selection
  typedef enum logic [1:0] {
    BCC_LRC,
    BCC_CRC16,
    BCC_CCITT
  } sbcg_mode_e;

  // transmit sequencer
  typedef enum logic [2:0] {
    TX_IDLE,
    TX_SYNC,
    TX_DATA,
    TX_BCC_HI,
    TX_BCC_LO
  } sbcg_tx_e;

  // receive framing
  typedef enum logic {
    RX_HUNT,
    RX_FRAMED
  } sbcg_rx_e;

endpackage

// File: test_sync_block_check_generator.sv
// Purpose: self-checking bench for the sync block check generator
// Assumes: inputs change on the falling clock edge
// Notes:   checks come from a bench model of parity sum and crc
`timescale 1ns/1ps
`include "sbcg_defs.svh"
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin \
  failures++; $display("Error at %0t: %s", $time, m); end end

module test_sync_block_check_generator;
  import sbcg_pkg::*;
  // ----------------------------------------------------------------------
  // stimulus and model
  // ----------------------------------------------------------------------
  logic       clk = 0, sys_rst = 1, par_en = 0, tx_blk_start = 0;
  logic       tx_in_valid = 0, tx_in_last = 0, rx_hunt = 0;
  logic       rx_count_en = 1, rx_blk_start = 0, rx_blk_end = 0;
  logic       stall_all = 0;
  logic [7:0] sync_char = 8'h32, tx_in_data = 8'h00;
  logic [3:0] sync_count = 4'h0;
  sbcg_mode_e bcc_mode = BCC_LRC;
  wire        tx_in_ready, tx_busy, tx_out_valid, tx_out_ready;
  wire        rx_line_data, rx_line_clk, rx_framed, rx_char_valid;
  wire        rx_par_err, rx_good, rx_bad;
  wire  [7:0] tx_out_data, rx_char_data;
  int         failures, comparisons, n_good, n_bad;
  logic [31:0] seed = 32'h6243;
  logic [8:0] rxq[$];
  logic [7:0] exq[$];

  sbcg_core dut (.clk(clk), .sys_rst(sys_rst), .bcc_mode(bcc_mode),
    .par_en(par_en), .sync_char(sync_char), .sync_count(sync_count),
    .tx_blk_start(tx_blk_start), .tx_in_valid(tx_in_valid),
    .tx_in_ready(tx_in_ready), .tx_in_data(tx_in_data),
    .tx_in_last(tx_in_last), .tx_busy(tx_busy),
    .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
    .tx_out_data(tx_out_data), .rx_line_data(rx_line_data),
    .rx_line_clk(rx_line_clk), .rx_hunt(rx_hunt), .rx_framed(rx_framed),
    .rx_char_valid(rx_char_valid), .rx_char_data(rx_char_data),
    .rx_par_err(rx_par_err), .rx_count_en(rx_count_en),
    .rx_blk_start(rx_blk_start), .rx_blk_end(rx_blk_end),
    .rx_good(rx_good), .rx_bad(rx_bad));
  sbcg_far_model far (.clk(clk), .stall_all(stall_all),
    .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data),
    .tx_out_ready(tx_out_ready), .rx_line_clk(rx_line_clk),
    .rx_line_data(rx_line_data));

  always #5 clk = ~clk;

  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  // one character into the check, crc msb first
  function automatic logic [15:0] step(logic [15:0] c, logic [7:0] ch,
                                       sbcg_mode_e m);
    logic [15:0] p;
    p = (m == BCC_CRC16) ? `SBCG_POLY_CRC16 : `SBCG_POLY_CCITT;
    if (m != BCC_CRC16 && m != BCC_CCITT) return c ^ {8'h00, ch};
    for (int i = 7; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ ch[i]) ? p : 16'h0000);
    return c;
  endfunction
  // received chars and verdicts, read before the edge updates land
  always @(posedge clk) begin
    if (rx_char_valid === 1'b1) rxq.push_back({rx_par_err, rx_char_data});
    if (rx_good === 1'b1) n_good++;
    if (rx_bad === 1'b1) n_bad++;
  end

  task automatic tx_block(sbcg_mode_e m, logic pe, logic [3:0] sc, int n);
    logic [15:0] acc;
    logic [7:0]  c;
    int          k;
    acc = 16'h0000;
    exq.delete();
    far.got.delete();
    bcc_mode = m;
    par_en = pe;
    sync_count = sc;
    tx_blk_start = 1'b1;
    repeat (2) @(negedge clk); // second start comes while busy
    tx_blk_start = 1'b0;
    for (k = 0; k < (sc == 0 ? 1 : sc); k++) exq.push_back(sync_char);
    for (int i = 0; i < n; i++) begin
      tx_in_data = rnd();
      c = tx_in_data;
      if (pe) c[7] = ~^c[6:0];
      exq.push_back(c);
      acc = step(acc, c, m);
      tx_in_valid = 1'b1;
      tx_in_last = (i == n - 1);
      k = 0;
      while (tx_in_ready !== 1'b1 && k < 300) begin
        @(negedge clk);
        k++;
      end
      if (k >= 300) failures++;
      @(negedge clk);
    end
    tx_in_valid = 1'b0;
    tx_in_last = 1'b0;
    if (m == BCC_CRC16 || m == BCC_CCITT) exq.push_back(acc[15:8]);
    exq.push_back(acc[7:0]);
    k = 0;
    while ((tx_busy !== 1'b0 || far.got.size() < exq.size()) && k < 500)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 500) failures++;
    repeat (4) @(negedge clk);
    `CHK(far.got.size(), exq.size(), "tx char count")
    foreach (exq[i]) `CHK(far.got[i], exq[i], "tx char")
  endtask

  task automatic rx_block(sbcg_mode_e m, logic pe, int n, logic bad);
    logic [15:0] acc;
    logic [7:0]  q[$];
    int          k;
    acc = 16'h0000;
    bcc_mode = m;
    par_en = pe;
    rxq.delete();
    n_good = 0;
    n_bad = 0;
    rx_hunt = 1'b1;
    @(negedge clk);
    rx_hunt = 1'b0;
    rx_blk_start = 1'b1;
    @(negedge clk);
    rx_blk_start = 1'b0;
    far.send_byte(8'h00);
    far.send_byte(sync_char);
    for (int i = 0; i < n; i++) begin
      q.push_back(rnd());
      acc = step(acc, q[i], m);
    end
    if (m == BCC_CRC16 || m == BCC_CCITT) q.push_back(acc[15:8]);
    q.push_back(acc[7:0]);
    if (bad) q[q.size() - 1][0] = ~q[q.size() - 1][0];
    foreach (q[i]) far.send_byte(q[i]);
    far.idle();
    k = 0;
    while (rxq.size() < q.size() && k < 100) begin
      @(negedge clk);
      k++;
    end
    if (k >= 100) failures++;
    @(negedge clk);
    rx_blk_end = 1'b1;
    @(negedge clk);
    rx_blk_end = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(rxq.size(), q.size(), "rx char count")
    foreach (q[i]) `CHK(rxq[i], {pe & ~^q[i], q[i]}, "rx char")
    `CHK(n_good, int'(!bad), "good verdict")
    `CHK(n_bad, int'(bad), "bad verdict")
  endtask

  task automatic give_verdict();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog, far beyond the expected run
  initial begin
    #400000;
    failures++;
    give_verdict();
  end
  // main sequence: tx in every mode, then rx good and bad blocks
  initial begin
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    stall_all = 1'b1;
    fork
      begin
        repeat (30) @(negedge clk);
        stall_all = 1'b0;
      end
    join_none
    tx_block(BCC_CRC16, 1'b0, 4'h0, 5);
    tx_block(BCC_CCITT, 1'b0, 4'h3, 4);
    tx_block(BCC_LRC, 1'b1, 4'h2, 4);
    tx_block(sbcg_mode_e'(2'h3), 1'b0, 4'h1, 1);
    for (int m = 0; m < 4; m++)
      for (int b = 0; b < 2; b++)
        rx_block(sbcg_mode_e'(m[1:0]), m == 0, 2 + m, b[0]);
    give_verdict();
  end
endmodule
